/* hw/oms_pkg.sv */
// Oscillator mode select: shared constants, mode codes and decoders.
// Assumes a single 50 MHz system clock drives all logic of the block.
package oms_pkg;

  // Oscillator select field codes (three-bit configuration field)
  localparam logic [2:0] MODE_EXTERNAL_CLOCK = 3'h0;
  localparam logic [2:0] MODE_LOW_POWER_XTAL = 3'h1;
  localparam logic [2:0] MODE_MEDIUM_GAIN_XTAL = 3'h2;
  localparam logic [2:0] MODE_HIGH_GAIN_XTAL = 3'h3;
  localparam logic [2:0] MODE_RES_CAP = 3'h4;
  localparam logic [2:0] MODE_RES_CAP_IO = 3'h5;
  localparam logic [2:0] MODE_INT_OSC_CLKOUT = 3'h6;
  localparam logic [2:0] MODE_INT_OSC_IO = 3'h7;
  localparam logic [2:0] OSC_SELECT_RESET = 3'h7;
  localparam logic FREQ_SELECT_RESET = 1'b1;

  // Crystal driver gain levels
  localparam logic [1:0] GAIN_NONE = 2'h0;
  localparam logic [1:0] GAIN_LOW = 2'h1;
  localparam logic [1:0] GAIN_MEDIUM = 2'h2;
  localparam logic [1:0] GAIN_HIGH = 2'h3;

  // Timing of the internal oscillator model
  localparam longint CLK_HZ = 50_000_000;
  localparam longint INT_OSC_HZ = 8_000_000;
  localparam int NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_NOM_INC =
    NCO_W'((INT_OSC_HZ * 64'h10000) / CLK_HZ);
  localparam int TRIM_W = 5;
  localparam int TRIM_SHIFT = 5;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 5'h00;
  localparam int CLKOUT_DIV = 4;

  // Internal oscillator is the clock source
  function automatic logic isInternal(input logic [2:0] m);
    return (m == MODE_INT_OSC_CLKOUT) || (m == MODE_INT_OSC_IO);
  endfunction

  // Output pin carries the divided clock
  function automatic logic hasClkout(input logic [2:0] m);
    return (m == MODE_RES_CAP) || (m == MODE_INT_OSC_CLKOUT);
  endfunction

  // Output pin is handed to port control
  function automatic logic outPinFree(input logic [2:0] m);
    return (m == MODE_EXTERNAL_CLOCK) || (m == MODE_RES_CAP_IO) ||
      (m == MODE_INT_OSC_IO);
  endfunction

endpackage

/* hw/oms_int_osc.sv */
// Internal oscillator model: phase accumulator giving tick pulses.
// Assumes the trim value is stable in the clock domain of clk.
`timescale 1ns/1ps
module oms_int_osc #(
  parameter int W = 16,
  parameter logic [W-1:0] NOM_INC = 16'h28F5,
  parameter int TRIM_W = 5,
  parameter int SHIFT = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [TRIM_W-1:0] trim,
  // Output
  output logic tick
);

  logic [W-1:0] acc_reg;
  logic [W-1:0] incVal;
  logic [W:0] sum;

  // Refuse widths that leave no room for the trim offset
  if (W < TRIM_W + SHIFT + 2) begin : g_bad_width
    $error("oms_int_osc: accumulator too narrow");
  end

  // Signed trim offset added to the nominal step
  assign incVal = NOM_INC + {{(W-TRIM_W-SHIFT){trim[TRIM_W-1]}},
    trim, {SHIFT{1'b0}}};
  assign sum = {1'b0, acc_reg} + {1'b0, incVal};

  // Accumulate; carry out is the oscillator tick
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_reg <= '0;
      tick <= 1'b0;
    end else if (run) begin
      acc_reg <= sum[W-1:0];
      tick <= sum[W];
    end else begin
      tick <= 1'b0;
    end
  end

endmodule // oms_int_osc

/* hw/oms_clk_div.sv */
// Clock divider: square wave toggling on source tick enables.
// Assumes ticks are one-cycle pulses on clk.
`timescale 1ns/1ps
module oms_clk_div #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic tick,
  // Output
  output logic clkOut
);

  localparam int CW = (DIV > 2) ? $clog2(DIV / 2) : 1;
  localparam logic [CW-1:0] HALF_LAST = CW'(DIV / 2 - 1);

  logic [CW-1:0] count_reg;

  // Only even ratios give a square wave
  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("oms_clk_div: DIV must be even and at least 2");
  end

  // Toggle every DIV/2 source ticks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= '0;
      clkOut <= 1'b0;
    end else if (clear) begin
      count_reg <= '0;
      clkOut <= 1'b0;
    end else if (tick) begin
      if (count_reg == HALF_LAST) begin
        count_reg <= '0;
        clkOut <= ~clkOut;
      end else begin
        count_reg <= count_reg + CW'(1);
      end
    end
  end

endmodule // oms_clk_div

/* hw/oms_osc_select.sv */
// Oscillator mode select: clock source choice and oscillator pin use.
// Assumes configuration inputs are static straps, pins come from outside
// the clk domain and port control runs on clk.
//
// Functional notes
// - Eight clock modes chosen by a three-bit oscillator select field.
// - External clock mode clocks from input pin, frees output pin.
// - Low-power mode serves 32 kHz crystal; medium/high gain serve resonators.
// - RC mode clocks from input pin, output pin shows frequency over four.
// - RC I/O mode clocks from input pin, output pin goes to port.
// - Internal modes run at 4 or 8 MHz by a frequency select bit.
// - 8 MHz comes straight from oscillator, 4 MHz via a postscaler.
// - Software writes a trim value that tunes the internal oscillator.
// - Internal clock-out mode frees input pin, drives output at clock/4.
// - Internal I/O mode gives both oscillator pins to the port.
`timescale 1ns/1ps
module oms_osc_select
  import oms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration word straps
  input wire logic [2:0] oscSelectCfg,
  input wire logic freqSelectCfg,
  // Frequency trim
  input wire logic trimWrEn,
  input wire logic [TRIM_W-1:0] trimWrData,
  output logic [TRIM_W-1:0] trimValue,
  // Oscillator input pin
  input wire logic oscInPinIn,
  output logic oscInPinOut,
  output logic oscInPinOe,
  // Oscillator output pin
  input wire logic oscOutPinIn,
  output logic oscOutPinOut,
  output logic oscOutPinOe,
  // Port control for the input pin
  input wire logic gpioInOut,
  input wire logic gpioInOe,
  output logic gpioInRead,
  // Port control for the output pin
  input wire logic gpioOutOut,
  input wire logic gpioOutOe,
  output logic gpioOutRead,
  // Status
  output logic sysClkTick,
  output logic [2:0] activeMode,
  output logic internalFast,
  output logic [1:0] crystalGain,
  output logic cfgValid
);

  logic [2:0] mode_reg;
  logic freqSel_reg;
  logic captured_reg;
  logic inSync1_reg;
  logic inSync2_reg;
  logic inPrev_reg;
  logic outSync1_reg;
  logic outSync2_reg;
  logic postHalf_reg;
  logic ncoTick;
  logic extTick;
  logic srcTick;
  logic divOut;
  logic internalSel;

  // Latch the configuration straps once, just after reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= OSC_SELECT_RESET;
      freqSel_reg <= FREQ_SELECT_RESET;
      captured_reg <= 1'b0;
    end else if (!captured_reg) begin
      mode_reg <= oscSelectCfg;
      freqSel_reg <= freqSelectCfg;
      captured_reg <= 1'b1;
    end
  end

  assign internalSel = captured_reg && isInternal(mode_reg);

  // Two-stage synchronisers for both oscillator pins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inSync1_reg <= 1'b0;
      inSync2_reg <= 1'b0;
      outSync1_reg <= 1'b0;
      outSync2_reg <= 1'b0;
    end else begin
      inSync1_reg <= oscInPinIn;
      inSync2_reg <= inSync1_reg;
      outSync1_reg <= oscOutPinIn;
      outSync2_reg <= outSync1_reg;
    end
  end

  // Rising edge of the external source on the input pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inPrev_reg <= 1'b0;
    end else begin
      inPrev_reg <= inSync2_reg;
    end
  end

  assign extTick = inSync2_reg && !inPrev_reg;

  // Trim register written by software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trimValue <= TRIM_RESET;
    end else if (trimWrEn) begin
      trimValue <= trimWrData;
    end
  end

  // Internal oscillator, tuned by the trim value
  oms_int_osc #(
    .W(NCO_W),
    .NOM_INC(NCO_NOM_INC),
    .TRIM_W(TRIM_W),
    .SHIFT(TRIM_SHIFT)
  ) u_int_osc (
    .clk(clk),
    .resetn(resetn),
    .run(internalSel),
    .trim(trimValue),
    .tick(ncoTick)
  );

  // Postscaler halving the internal oscillator for the slow setting
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      postHalf_reg <= 1'b0;
    end else if (ncoTick) begin
      postHalf_reg <= ~postHalf_reg;
    end
  end

  // Source tick: 8 MHz direct, 4 MHz via postscaler, else the pin
  always_comb begin
    if (internalSel) begin
      srcTick = freqSel_reg ? ncoTick : (ncoTick && postHalf_reg);
    end else begin
      srcTick = captured_reg && extTick;
    end
  end

  // System clock enable pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sysClkTick <= 1'b0;
    end else begin
      sysClkTick <= srcTick;
    end
  end

  // Divide-by-four clock for the output pin
  oms_clk_div #(
    .DIV(CLKOUT_DIV)
  ) u_clkout (
    .clk(clk),
    .resetn(resetn),
    .clear(!(captured_reg && hasClkout(mode_reg))),
    .tick(srcTick),
    .clkOut(divOut)
  );

  // Crystal driver gain follows the selected crystal mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crystalGain <= GAIN_NONE;
    end else if (!captured_reg) begin
      crystalGain <= GAIN_NONE;
    end else begin
      unique case (mode_reg)
        MODE_LOW_POWER_XTAL: crystalGain <= GAIN_LOW;
        MODE_MEDIUM_GAIN_XTAL: crystalGain <= GAIN_MEDIUM;
        MODE_HIGH_GAIN_XTAL: crystalGain <= GAIN_HIGH;
        default: crystalGain <= GAIN_NONE;
      endcase
    end
  end

  // Input pin: port control in internal modes, else an oscillator input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscInPinOut <= 1'b0;
      oscInPinOe <= 1'b0;
    end else if (internalSel) begin
      oscInPinOut <= gpioInOut;
      oscInPinOe <= gpioInOe;
    end else begin
      oscInPinOut <= 1'b0;
      oscInPinOe <= 1'b0;
    end
  end

  // Output pin: clock out, crystal feedback, or port control
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oscOutPinOut <= 1'b0;
      oscOutPinOe <= 1'b0;
    end else if (!captured_reg) begin
      oscOutPinOut <= 1'b0;
      oscOutPinOe <= 1'b0;
    end else if (hasClkout(mode_reg)) begin
      oscOutPinOut <= divOut;
      oscOutPinOe <= 1'b1;
    end else if (outPinFree(mode_reg)) begin
      oscOutPinOut <= gpioOutOut;
      oscOutPinOe <= gpioOutOe;
    end else begin
      oscOutPinOut <= ~inSync2_reg;
      oscOutPinOe <= 1'b1;
    end
  end

  // Port read-back of both pin levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpioInRead <= 1'b0;
      gpioOutRead <= 1'b0;
    end else begin
      gpioInRead <= inSync2_reg;
      gpioOutRead <= outSync2_reg;
    end
  end

  // Status outputs
  assign activeMode = mode_reg;
  assign internalFast = freqSel_reg;
  assign cfgValid = captured_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_mode_held: assert property (
    captured_reg |=> $stable(mode_reg) && $stable(freqSel_reg)
  ) else $error("mode changed while running");

  a_ext_out_free: assert property (
    captured_reg && mode_reg == MODE_EXTERNAL_CLOCK
    |=> oscOutPinOe == $past(gpioOutOe)
  ) else $error("external mode output pin not freed");

  a_xtal_gain: assert property (
    captured_reg && mode_reg == MODE_LOW_POWER_XTAL
    |=> crystalGain == GAIN_LOW && oscOutPinOe
  ) else $error("low power crystal gain wrong");

  a_rc_clkout: assert property (
    captured_reg && mode_reg == MODE_RES_CAP
    |=> oscOutPinOe && oscOutPinOut == $past(divOut)
  ) else $error("rc clock out missing");

  a_rc_tick: assert property (
    captured_reg && !internalSel && extTick |=> sysClkTick
  ) else $error("external edge gave no clock tick");

  a_resistor_capacitor_io_mode_free: assert property (
    captured_reg && mode_reg == MODE_RES_CAP_IO
    |=> oscOutPinOut == $past(gpioOutOut)
  ) else $error("rc io output pin not freed");

  a_int_fast: assert property (
    internalSel && freqSel_reg && ncoTick |=> sysClkTick
  ) else $error("8 MHz tick lost");

  a_int_slow: assert property (
    internalSel && !freqSel_reg && srcTick
    |=> sysClkTick ##1 !sysClkTick [*8]
  ) else $error("4 MHz ticks too close");

  a_trim_load: assert property (
    trimWrEn |=> trimValue == $past(trimWrData)
  ) else $error("trim value not loaded");

  a_int_clkout: assert property (
    internalSel && mode_reg == MODE_INT_OSC_CLKOUT
    |=> oscInPinOe == $past(gpioInOe) && oscOutPinOe
  ) else $error("internal clock out pins wrong");

  a_int_io: assert property (
    internalSel && mode_reg == MODE_INT_OSC_IO
    |=> oscInPinOe == $past(gpioInOe) && oscOutPinOe == $past(gpioOutOe)
  ) else $error("internal io pins not freed");

  c_rc_clkout: cover property (
    mode_reg == MODE_RES_CAP && $rose(oscOutPinOut)
  );

  c_int_slow: cover property (
    internalSel && !freqSel_reg && sysClkTick
  );

  c_trim_write: cover property (
    trimWrEn && trimWrData != TRIM_RESET
  );

endmodule // oms_osc_select

/* test/oms_osc_source.sv */
// Far side of the oscillator pins: external clock or RC network model.
// Assumes the bench sets the half period in ns and starts or stops it.
`timescale 1ns/1ps
module oms_osc_source (
  // Control from the bench
  input wire logic run,
  input wire logic [7:0] halfNs,
  // Design drive of both pins
  input wire logic inOe,
  input wire logic inOut,
  input wire logic outOe,
  input wire logic outOut,
  // Resolved pin levels
  output logic inPin,
  output logic outPin
);
  logic src = 1'b0;

  // Source toggles only while running, stands low otherwise
  always begin
    if (run) begin
      #(halfNs) src = ~src;
    end else begin
      src = 1'b0;
      #10;
    end
  end

  // Pin drive wins over the source; the output pin has a pull-up
  assign inPin = inOe ? inOut : src;
  assign outPin = outOe ? outOut : 1'b1;
endmodule // oms_osc_source

/* test/oms_osc_select_bench.sv */
// Self-checking bench for the oscillator mode select block.
// Assumes one 50 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module oms_osc_select_bench;
  import oms_pkg::*;
  typedef struct {logic [2:0] m; logic f; logic [1:0] g;} oms_note_type;
  logic clk = 0, resetn = 0, fSel = 0, trimWrEn = 0, run = 0;
  logic [2:0] mSel = 0;
  logic [TRIM_W-1:0] trimWrData = 0, trimValue, trimPrev = 0;
  logic inPin, outPin, inPOut, inPOe, outPOut, outPOe;
  logic gInOut = 0, gInOe = 0, gOutOut = 0, gOutOe = 0, gInRd, gOutRd;
  logic sysClkTick, internalFast, cfgValid, seen = 0, cfgPrev = 0;
  logic [2:0] activeMode;
  logic [1:0] crystalGain;
  logic [7:0] halfNs = 8'h50;
  oms_note_type cfgQ[$];
  logic [TRIM_W-1:0] trimQ[$];
  int error_cnt = 0, checks_done = 0, ticks, edges;
  oms_osc_select oms_osc_select_inst (.clk(clk), .resetn(resetn),
    .oscSelectCfg(mSel), .freqSelectCfg(fSel), .trimWrEn(trimWrEn),
    .trimWrData(trimWrData), .trimValue(trimValue), .oscInPinIn(inPin),
    .oscInPinOut(inPOut), .oscInPinOe(inPOe), .oscOutPinIn(outPin),
    .oscOutPinOut(outPOut), .oscOutPinOe(outPOe), .gpioInOut(gInOut),
    .gpioInOe(gInOe), .gpioInRead(gInRd), .gpioOutOut(gOutOut),
    .gpioOutOe(gOutOe), .gpioOutRead(gOutRd), .sysClkTick(sysClkTick),
    .activeMode(activeMode), .internalFast(internalFast),
    .crystalGain(crystalGain), .cfgValid(cfgValid));
  oms_osc_source oms_osc_source_inst (.run(run), .halfNs(halfNs),
    .inOe(inPOe), .inOut(inPOut), .outOe(outPOe), .outOut(outPOut),
    .inPin(inPin), .outPin(outPin));

  // Clock generator
  always #10 clk = ~clk;

  // Value compare
  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask

  // Count compare with tolerance
  task automatic near(string n, int e, int s, int tol);
    checks_done++;
    if (s < e - tol || s > e + tol) begin
      $display("[ERR] %s expected %0d seen %0d", n, e, s);
      error_cnt++;
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    error_cnt += cfgQ.size() + trimQ.size();
    $display("Counts: %0d checks, %0d errors", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watcher: latched straps and trim value against the oldest note
  always @(negedge clk) begin
    oms_note_type n;
    if (resetn === 1'b0) begin
      seen <= 1'b0;
    end else if (cfgValid === 1'b1 && cfgPrev === 1'b1 && !seen &&
      cfgQ.size() > 0) begin
      n = cfgQ.pop_front();
      seen <= 1'b1;
      check("activeMode", 8'(n.m), 8'(activeMode));
      check("internalFast", 8'(n.f), 8'(internalFast));
      check("crystalGain", 8'(n.g), 8'(crystalGain));
    end
    if (trimValue !== trimPrev && trimQ.size() > 0) begin
      check("trimValue", 8'(trimQ.pop_front()), 8'(trimValue));
    end
    trimPrev <= trimValue;
    // Gain settles one cycle after the straps are latched
    cfgPrev <= cfgValid;
  end

  // Reset with straps applied, then disturb the straps
  task automatic startMode(logic [2:0] m, logic f);
    oms_note_type n;
    int i;
    resetn = 0;
    mSel = m;
    fSel = f;
    repeat (8) @(negedge clk);
    n.m = m;
    n.f = f;
    n.g = (m == 3'h1) ? GAIN_LOW : (m == 3'h2) ? GAIN_MEDIUM :
      (m == 3'h3) ? GAIN_HIGH : GAIN_NONE;
    cfgQ.push_back(n);
    resetn = 1;
    for (i = 0; i < 4 && cfgValid !== 1'b1; i++) @(negedge clk);
    if (cfgValid !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
    mSel = 3'($urandom());
    fSel = ~f;
    repeat (3) @(negedge clk);
  endtask

  // Count ticks and clock-out rising edges over 800 cycles
  task automatic measure();
    logic prev;
    ticks = 0;
    edges = 0;
    prev = outPOut;
    repeat (800) begin
      @(negedge clk);
      ticks += (sysClkTick === 1'b1);
      edges += (outPOut === 1'b1 && prev === 1'b0);
      prev = outPOut;
    end
  endtask

  // Trim write; strobe stays up between back-to-back writes
  task automatic writeTrim(logic [TRIM_W-1:0] d, logic last);
    trimWrEn = 1;
    trimWrData = d;
    trimQ.push_back(d);
    @(negedge clk);
    if (last) trimWrEn = 0;
  endtask

  initial begin
    logic outFree, inFree, clkOut, v;
    void'($urandom(87791));
    for (int k = 0; k < 16; k++) begin
      logic [2:0] m;
      m = 3'(k >> 1);
      outFree = (m == 3'h0 || m == 3'h5 || m == 3'h7);
      inFree = (m >= 3'h6);
      clkOut = (m == 3'h4 || m == 3'h6);
      run = (m < 3'h6);
      gOutOe = 0;
      gInOe = 1;
      gInOut = 1'($urandom());
      startMode(m, k[0]);
      check("outPinOe", 8'(!outFree), 8'(outPOe));
      check("inPinOe", 8'(inFree), 8'(inPOe));
      if (inFree) check("inPinOut", 8'(gInOut), 8'(inPOut));
      measure();
      if (m < 3'h6) near("extTicks", 100, ticks, 1);
      else near("intTicks", k[0] ? 128 : 64, ticks, 2);
      if (inFree) check("inRead", 8'(gInOut), 8'(gInRd));
      if (clkOut) near("clkOut", ticks / 4, edges, 1);
      else check("clkOutIdle", 8'(!outFree), 8'(outPOe));
      if (outFree) begin
        v = 1'($urandom());
        gOutOe = 1;
        gOutOut = v;
        repeat (5) @(negedge clk);
        check("outPinOut", 8'(v), 8'(outPOut));
        check("outRead", 8'(v), 8'(gOutRd));
      end
      check("modeHeld", 8'(m), 8'(activeMode));
      $display("Test mode %0d speed %0d done", m, k[0]);
    end
    // Trim: back-to-back writes, then rate shifts both ways
    run = 0;
    startMode(3'h7, 1'b1);
    writeTrim(5'h05, 1'b0);
    writeTrim(5'h0F, 1'b1);
    measure();
    near("trimUp", 134, ticks, 2);
    writeTrim(5'h10, 1'b1);
    measure();
    near("trimDown", 122, ticks, 2);
    $display("Test trim done");
    print_verdict();
  end
endmodule // oms_osc_select_bench
